// ===== rtl/dui_ctrl.v
// Purpose: interrupt control of a dual serial controller, AHB-Lite register slave
// Assumes: channel status levels arrive on hclk; input pins are asynchronous
// Notes:   open-drain pins report low drive through their enable
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dui_map.vh"
module dui_ctrl #(
	parameter CT_W     = 16,
	parameter OSC_DIV  = `DUI_OSC_DIV,
	parameter SAMP_DIV = `DUI_SAMP_DIV
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	input  wire [1:0]  tx_can_accept,
	input  wire [1:0]  rx_char_avail,
	input  wire [1:0]  rx_buffer_full,
	input  wire [1:0]  break_change,
	input  wire [7:0]  rx_data_a,
	input  wire [7:0]  rx_data_b,
	input  wire [3:0]  input_pins,
	output reg         irq_request_n,
	output reg         irq,
	output reg  [7:0]  tx_data,
	output reg  [1:0]  tx_load,
	output reg  [1:0]  rx_read,
	output reg  [4:0]  out_pins_three_to_seven,
	output reg  [4:0]  out_pins_three_to_seven_oe
);
	function addr_is;
		input [31:0] a;
		input [7:0]  off;
		begin
			addr_is = (a == {24'h000000, off});
		end
	endfunction

	// bus phases
	reg        wr_q;
	reg [31:0] waddr_q;
	wire acc    = hsel & htrans[1] & hready;
	wire rd_acc = acc & ~hwrite;

	function wr_hit;
		input        wq;
		input [31:0] a;
		input [7:0]  off;
		begin
			wr_hit = wq & addr_is(a, off);
		end
	endfunction

	// registers
	reg [7:0]      irq_mask_reg_q;
	reg [7:0]      aux_control_reg_q;
	reg [14:0]     opcfg_q;
	reg [CT_W-1:0] ct_preset_q;
	reg [1:0]      evt_q;
	reg [1:0]      evt_mask_q;
	reg            ctr_flag_q;
	reg [3:0]      delta_q;
	reg [3:0]      lvl_q;
	reg [3:0]      smp_q;
	reg            primed_q;
	reg [3:0]      pin_s1_q;
	reg [3:0]      pin_s2_q;
	reg [7:0]      osc_cnt_q;
	reg [7:0]      samp_cnt_q;
	reg            osc_tick_q;
	reg            samp_tick_q;

	wire [4:0] func_en = opcfg_q[`DUI_OPCFG_FUNC_LSB +: 5];
	wire [4:0] gp_val  = opcfg_q[`DUI_OPCFG_GP_LSB +: 5];
	wire [1:0] rx_mode = opcfg_q[`DUI_OPCFG_RXM_LSB +: 2];

	// one-cycle pulses decoded from data phase writes
	wire wr_hold_a = wr_hit(wr_q, waddr_q, `DUI_OFF_HOLD_A);
	wire wr_hold_b = wr_hit(wr_q, waddr_q, `DUI_OFF_HOLD_B);
	wire wr_cmd_a  = wr_hit(wr_q, waddr_q, `DUI_OFF_CMD_A);
	wire wr_cmd_b  = wr_hit(wr_q, waddr_q, `DUI_OFF_CMD_B);
	wire wr_ct     = wr_hit(wr_q, waddr_q, `DUI_OFF_CT_CTRL);
	wire ct_start  = wr_ct & hwdata[`DUI_CT_START];
	wire ct_stop   = wr_ct & hwdata[`DUI_CT_STOP];
	wire brk_cmd   = (hwdata[`DUI_CMD_LSB +: 4] == `DUI_CMD_RST_BRK);
	wire [1:0] wr_hold = {wr_hold_b, wr_hold_a};
	wire [1:0] wr_cmd  = {wr_cmd_b, wr_cmd_a};

	// oscillator-rate and sampling-rate enables
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_cnt_q   <= 8'h00;
			samp_cnt_q  <= 8'h00;
			osc_tick_q  <= 1'b0;
			samp_tick_q <= 1'b0;
		end else begin
			osc_tick_q  <= 1'b0;
			samp_tick_q <= 1'b0;
			if (osc_cnt_q == OSC_DIV[7:0] - 8'h01) begin
				osc_cnt_q  <= 8'h00;
				osc_tick_q <= 1'b1;
				if (samp_cnt_q == SAMP_DIV[7:0] - 8'h01) begin
					samp_cnt_q  <= 8'h00;
					samp_tick_q <= 1'b1;
				end else begin
					samp_cnt_q <= samp_cnt_q + 8'h01;
				end
			end else begin
				osc_cnt_q <= osc_cnt_q + 8'h01;
			end
		end
	end

	// per-channel transmit, receive, break and command spacing
	wire [1:0] tx_cond;
	wire [1:0] rx_cond;
	wire [1:0] brk_cond;
	wire [1:0] gap_viol;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : ch
			reg       tx_pend_q;
			reg       brk_q;
			reg [1:0] gap_q;
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					tx_pend_q <= 1'b0;
					brk_q     <= 1'b0;
					gap_q     <= 2'd3;
				end else begin
					if (wr_hold[gi])
						tx_pend_q <= 1'b1;
					else if (!tx_can_accept[gi])
						tx_pend_q <= 1'b0;
					if (break_change[gi])
						brk_q <= 1'b1;
					else if (wr_cmd[gi] && brk_cmd)
						brk_q <= 1'b0;
					if (wr_cmd[gi])
						gap_q <= 2'd0;
					else if (osc_tick_q && gap_q != 2'd3)
						gap_q <= gap_q + 2'd1;
				end
			end
			assign tx_cond[gi]  = tx_can_accept[gi] & ~tx_pend_q;
			assign rx_cond[gi]  = rx_mode[gi] ? rx_buffer_full[gi] : rx_char_avail[gi];
			assign brk_cond[gi] = brk_q;
			assign gap_viol[gi] = wr_cmd[gi] && (gap_q < `DUI_CMD_GAP);
		end
	endgenerate

	// counter/timer
	wire            ct_zero;
	wire            ct_running;
	wire [CT_W-1:0] ct_count;
	dui_ctr #(
		.W (CT_W)
	) u_ctr (
		.clk        (hclk),
		.rst_n      (hresetn),
		.tick       (osc_tick_q),
		.preset     (ct_preset_q),
		.start      (ct_start),
		.stop       (ct_stop),
		.zero_pulse (ct_zero),
		.running    (ct_running),
		.count      (ct_count)
	);

	// input change detection
	wire       rd_inchg = rd_acc & addr_is(haddr, `DUI_OFF_INCHG);
	wire [3:0] new_chg  = (samp_tick_q && primed_q) ?
		((pin_s2_q ^ lvl_q) & ~(pin_s2_q ^ smp_q)) : 4'h0;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1_q <= 4'h0;
			pin_s2_q <= 4'h0;
			smp_q    <= 4'h0;
			lvl_q    <= 4'h0;
			primed_q <= 1'b0;
			delta_q  <= 4'h0;
		end else begin
			pin_s1_q <= input_pins;
			pin_s2_q <= pin_s1_q;
			if (samp_tick_q) begin
				smp_q <= pin_s2_q;
				if (!primed_q) begin
					lvl_q    <= pin_s2_q;
					primed_q <= 1'b1;
				end else begin
					// two samples at new level
					lvl_q <= lvl_q ^ new_chg;
				end
			end
			delta_q <= (delta_q & ~{4{rd_inchg}}) | new_chg;
		end
	end

	// break, counter and input-change terms held until their clear; receive terms follow their levels; a hold write masks the transmit term until its level falls
	wire [7:0] status;
	assign status[`DUI_ST_TX_A]  = tx_cond[0];
	assign status[`DUI_ST_RX_A]  = rx_cond[0];
	assign status[`DUI_ST_BRK_A] = brk_cond[0];
	assign status[`DUI_ST_CTR]   = ctr_flag_q;
	assign status[`DUI_ST_TX_B]  = tx_cond[1];
	assign status[`DUI_ST_RX_B]  = rx_cond[1];
	assign status[`DUI_ST_BRK_B] = brk_cond[1];
	assign status[`DUI_ST_INCHG] = |(delta_q & aux_control_reg_q[3:0]);

	wire [7:0] masked = status & irq_mask_reg_q;
	wire       rd_evt = rd_acc & addr_is(haddr, `DUI_OFF_EVT);
	wire [1:0] evt_set;
	assign evt_set[`DUI_EV_IRQ]     = (|masked) & irq_request_n;
	assign evt_set[`DUI_EV_CMD_GAP] = |gap_viol;

	// read data, registered for the data phase
	reg [31:0] rdata_d;
	always @* begin
		rdata_d = 32'h00000000;
		if (addr_is(haddr, `DUI_OFF_MASK))
			rdata_d = {24'h000000, irq_mask_reg_q};
		else if (addr_is(haddr, `DUI_OFF_STATUS))
			rdata_d = {24'h000000, status};
		else if (addr_is(haddr, `DUI_OFF_AUX))
			rdata_d = {24'h000000, aux_control_reg_q};
		else if (addr_is(haddr, `DUI_OFF_INCHG))
			rdata_d = {24'h000000, lvl_q, delta_q};
		else if (addr_is(haddr, `DUI_OFF_HOLD_A))
			rdata_d = {24'h000000, rx_data_a};
		else if (addr_is(haddr, `DUI_OFF_HOLD_B))
			rdata_d = {24'h000000, rx_data_b};
		else if (addr_is(haddr, `DUI_OFF_CT_PRESET))
			rdata_d = {{(32-CT_W){1'b0}}, ct_preset_q};
		else if (addr_is(haddr, `DUI_OFF_CT_CTRL))
			rdata_d = {ct_count, 15'h0000, ct_running};
		else if (addr_is(haddr, `DUI_OFF_OPCFG))
			rdata_d = {17'h00000, opcfg_q};
		else if (addr_is(haddr, `DUI_OFF_EVT))
			rdata_d = {30'h00000000, evt_q};
		else if (addr_is(haddr, `DUI_OFF_EVT_MASK))
			rdata_d = {30'h00000000, evt_mask_q};
	end

	// bus slave and registers
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q              <= 1'b0;
			waddr_q           <= 32'h00000000;
			hrdata            <= 32'h00000000;
			hreadyout         <= 1'b1;
			hresp             <= 1'b0;
			irq_mask_reg_q    <= `DUI_RST_MASK;
			aux_control_reg_q <= `DUI_RST_AUX;
			opcfg_q           <= `DUI_RST_OPCFG;
			ct_preset_q       <= `DUI_RST_PRESET;
			evt_mask_q        <= 2'b00;
			evt_q             <= 2'b00;
			ctr_flag_q        <= 1'b0;
			tx_data           <= 8'h00;
			tx_load           <= 2'b00;
			rx_read           <= 2'b00;
		end else begin
			wr_q    <= acc & hwrite;
			waddr_q <= haddr;
			if (rd_acc)
				hrdata <= rdata_d;
			rx_read <= {rd_acc & addr_is(haddr, `DUI_OFF_HOLD_B),
				rd_acc & addr_is(haddr, `DUI_OFF_HOLD_A)};
			tx_load <= wr_hold;
			if (|wr_hold)
				tx_data <= hwdata[7:0];
			// mask write takes effect next edge
			if (wr_hit(wr_q, waddr_q, `DUI_OFF_MASK))
				irq_mask_reg_q <= hwdata[7:0];
			if (wr_hit(wr_q, waddr_q, `DUI_OFF_AUX))
				aux_control_reg_q <= hwdata[7:0];
			if (wr_hit(wr_q, waddr_q, `DUI_OFF_OPCFG))
				opcfg_q <= hwdata[14:0];
			if (wr_hit(wr_q, waddr_q, `DUI_OFF_CT_PRESET))
				ct_preset_q <= hwdata[CT_W-1:0];
			if (wr_hit(wr_q, waddr_q, `DUI_OFF_EVT_MASK))
				evt_mask_q <= hwdata[1:0];
			if (ct_zero)
				ctr_flag_q <= 1'b1;
			else if (ct_stop)
				ctr_flag_q <= 1'b0;
			evt_q <= (evt_q & ~{2{rd_evt}}) | evt_set;
		end
	end

	// request outputs and function pins
	wire [4:0] pin_cond = {tx_cond[1], tx_cond[0], rx_cond[1], rx_cond[0], ctr_flag_q};
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_request_n              <= 1'b1;
			irq                        <= 1'b0;
			out_pins_three_to_seven    <= 5'h1f;
			out_pins_three_to_seven_oe <= 5'h1f;
		end else begin
			irq_request_n <= ~(|masked);
			irq           <= |(evt_q & evt_mask_q);
			out_pins_three_to_seven    <= ~gp_val & ~func_en;
			out_pins_three_to_seven_oe <= ~func_en | pin_cond;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/dui_map.vh
// Purpose: register map, field positions and timing counts of the interrupt control block
// Assumes: 32-bit AHB-Lite slave, one aligned word per register
// Notes:   byte addresses
`ifndef DUI_MAP_VH
`define DUI_MAP_VH

`define DUI_OFF_MASK      8'h00
`define DUI_OFF_STATUS    8'h04
`define DUI_OFF_AUX       8'h08
`define DUI_OFF_INCHG     8'h0c
`define DUI_OFF_HOLD_A    8'h10
`define DUI_OFF_HOLD_B    8'h14
`define DUI_OFF_CMD_A     8'h18
`define DUI_OFF_CMD_B     8'h1c
`define DUI_OFF_CT_PRESET 8'h20
`define DUI_OFF_CT_CTRL   8'h24
`define DUI_OFF_OPCFG     8'h28
`define DUI_OFF_EVT       8'h2c
`define DUI_OFF_EVT_MASK  8'h30

// status bit positions
`define DUI_ST_TX_A       0
`define DUI_ST_RX_A       1
`define DUI_ST_BRK_A      2
`define DUI_ST_CTR        3
`define DUI_ST_TX_B       4
`define DUI_ST_RX_B       5
`define DUI_ST_BRK_B      6
`define DUI_ST_INCHG      7

// channel command field and the break-change reset code
`define DUI_CMD_LSB       4
`define DUI_CMD_RST_BRK   4'h5

// counter control write bits
`define DUI_CT_START      0
`define DUI_CT_STOP       1

// output config fields
`define DUI_OPCFG_FUNC_LSB 0
`define DUI_OPCFG_GP_LSB   8
`define DUI_OPCFG_RXM_LSB  13

// event status bits
`define DUI_EV_IRQ        0
`define DUI_EV_CMD_GAP    1

// reset values
`define DUI_RST_MASK      8'h00
`define DUI_RST_AUX       8'h00
`define DUI_RST_OPCFG     15'h0000
`define DUI_RST_PRESET    16'hffff

// timing: 100 MHz hclk, oscillator rate 3.6864 MHz, sampling 38.4 kHz
`define DUI_HCLK_HZ       100000000
`define DUI_OSC_HZ        3686400
`define DUI_SAMP_HZ       38400
`define DUI_OSC_DIV       (`DUI_HCLK_HZ / `DUI_OSC_HZ)
`define DUI_SAMP_DIV      (`DUI_OSC_HZ / `DUI_SAMP_HZ)
`define DUI_CMD_GAP       3

`endif

// ===== rtl/dui_ctr.v
// Purpose: down counter that flags each pass through zero
// Assumes: tick is a one-cycle enable at the oscillator rate
// Notes:   reloads the preset at zero and keeps running until stopped
`timescale 1ns/1ps
`default_nettype none
module dui_ctr #(
	parameter W = 16
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire         tick,
	input  wire [W-1:0] preset,
	input  wire         start,
	input  wire         stop,
	output reg          zero_pulse,
	output reg          running,
	output reg  [W-1:0] count
);
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			zero_pulse <= 1'b0;
			running    <= 1'b0;
			count      <= {W{1'b0}};
		end else begin
			zero_pulse <= 1'b0;
			if (stop) begin
				running <= 1'b0;
			end else if (start) begin
				running <= 1'b1;
				count   <= preset;
			end else if (running && tick) begin
				if (count == {W{1'b0}}) begin
					zero_pulse <= 1'b1;
					count      <= preset;
				end else begin
					count <= count - {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb/dui_ctrl_monitor.sv
// Purpose: port checks of the interrupt control slave
// Assumes: word accesses below byte address 0x100
// Notes:   mask and pin config are tracked from bus writes
`timescale 1ns/1ps
`default_nettype none
`include "dui_map.vh"
module dui_ctrl_monitor (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [7:0]  rx_data_a,
	input wire logic        irq_request_n,
	input wire logic [7:0]  tx_data,
	input wire logic [1:0]  tx_load,
	input wire logic [1:0]  rx_read,
	input wire logic [4:0]  out_pins_three_to_seven,
	input wire logic [4:0]  out_pins_three_to_seven_oe
);
	logic       v_q;
	logic       w_q;
	logic [7:0] a_q;
	logic [7:0] mask_q;
	logic [4:0] cfg_q;
	wire logic  take = hsel & htrans[1] & hready;
	wire logic  wr_ph = v_q & w_q;
	wire logic  rd_ph = v_q & ~w_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			v_q <= 1'b0;
			w_q <= 1'b0;
			a_q <= 8'h00;
			mask_q <= 8'h00;
			cfg_q <= 5'h00;
		end else begin
			if (hready) begin
				v_q <= take;
				w_q <= hwrite;
				a_q <= haddr[7:0];
			end
			if (wr_ph && a_q == `DUI_OFF_MASK)
				mask_q <= hwdata[7:0];
			if (wr_ph && a_q == `DUI_OFF_OPCFG)
				cfg_q <= hwdata[4:0];
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	rd_hold_a: assert property (!(take && !hwrite) |=> $stable(hrdata))
		else $error("read data moved without a read");
	mask_gate_a: assert property (!irq_request_n |-> $past(mask_q) != 8'h00)
		else $error("request with all masked");
	mask_off_a: assert property (mask_q == 8'h00 |=> irq_request_n)
		else $error("request after mask cleared");
	tx_pulse_a: assert property (wr_ph && a_q == `DUI_OFF_HOLD_A |=> tx_load == 2'b01)
		else $error("no load pulse");
	tx_value_a: assert property (wr_ph && a_q == `DUI_OFF_HOLD_A
		|=> {24'h0, tx_data} == ($past(hwdata) & 32'hff))
		else $error("wrong tx data");
	tx_only_a: assert property (tx_load != 2'b00 |-> $past(wr_ph))
		else $error("load pulse without write");
	rx_pulse_a: assert property (rd_ph && a_q == `DUI_OFF_HOLD_A |-> rx_read == 2'b01)
		else $error("no read pulse");
	rx_value_a: assert property (rd_ph && a_q == `DUI_OFF_HOLD_A
		|-> hrdata[7:0] == $past(rx_data_a))
		else $error("wrong rx data");
	fn_drain_a: assert property ((cfg_q & $past(cfg_q) & out_pins_three_to_seven) == 5'h00)
		else $error("function pin driven high");
	gp_drive_a: assert property ((~cfg_q & ~$past(cfg_q) & ~out_pins_three_to_seven_oe) == 5'h00)
		else $error("port pin not driven");
	cover property (!irq_request_n);
	cover property (tx_load == 2'b01);
	cover property (rx_read == 2'b01);
	cover property (cfg_q != 5'h00 && out_pins_three_to_seven_oe != 5'h1f);
endmodule
bind dui_ctrl dui_ctrl_monitor mon (
	.hclk                       (hclk),
	.hresetn                    (hresetn),
	.hsel                       (hsel),
	.haddr                      (haddr),
	.htrans                     (htrans),
	.hwrite                     (hwrite),
	.hwdata                     (hwdata),
	.hready                     (hready),
	.hrdata                     (hrdata),
	.hreadyout                  (hreadyout),
	.hresp                      (hresp),
	.rx_data_a                  (rx_data_a),
	.irq_request_n              (irq_request_n),
	.tx_data                    (tx_data),
	.tx_load                    (tx_load),
	.rx_read                    (rx_read),
	.out_pins_three_to_seven    (out_pins_three_to_seven),
	.out_pins_three_to_seven_oe (out_pins_three_to_seven_oe)
);
`default_nettype wire

// ===== tb/dui_host.sv
// Purpose: host bus master model
// Assumes: single word transfers, one slave
// Notes:   waits on hready with no fixed latency
`timescale 1ns/1ps
`default_nettype none
module dui_host #(
	parameter int GAP = 6
) (
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output var  logic        hsel,
	output var  logic [31:0] haddr,
	output var  logic [1:0]  htrans,
	output var  logic        hwrite,
	output var  logic [2:0]  hsize,
	output var  logic [31:0] hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hwdata <= ~hwdata;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
		if (w && a[7:3] == 5'h03)
			repeat (GAP) @(posedge hclk);
	endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: self-checking bench of the interrupt control slave
// Assumes: short oscillator and sampling dividers
// Notes:   channel levels driven here, bus through the host model
`timescale 1ns/1ps
`default_nettype none
`include "dui_map.vh"
module testbench;
	logic        hclk;
	logic        hresetn;
	logic        hsel, hwrite, hready, hreadyout, hresp, irq_request_n, irq;
	logic [31:0] haddr, hwdata, hrdata;
	logic [2:0]  hsize;
	logic [1:0]  htrans, tx_can_accept, rx_char_avail, rx_buffer_full, break_change;
	logic [1:0]  tx_load, rx_read;
	logic [7:0]  rx_data_a, rx_data_b, tx_data;
	logic [3:0]  input_pins;
	logic [4:0]  out_pins_three_to_seven, out_pins_three_to_seven_oe;
	int          err_total = 0;
	int          checked = 0;
	int          cyc = 0;
	assign hready = hreadyout;
	dui_ctrl #(
		.OSC_DIV  (2),
		.SAMP_DIV (2)
	) dut (
		.hclk                       (hclk),
		.hresetn                    (hresetn),
		.hsel                       (hsel),
		.haddr                      (haddr),
		.htrans                     (htrans),
		.hwrite                     (hwrite),
		.hsize                      (hsize),
		.hwdata                     (hwdata),
		.hready                     (hready),
		.hrdata                     (hrdata),
		.hreadyout                  (hreadyout),
		.hresp                      (hresp),
		.tx_can_accept              (tx_can_accept),
		.rx_char_avail              (rx_char_avail),
		.rx_buffer_full             (rx_buffer_full),
		.break_change               (break_change),
		.rx_data_a                  (rx_data_a),
		.rx_data_b                  (rx_data_b),
		.input_pins                 (input_pins),
		.irq_request_n              (irq_request_n),
		.irq                        (irq),
		.tx_data                    (tx_data),
		.tx_load                    (tx_load),
		.rx_read                    (rx_read),
		.out_pins_three_to_seven    (out_pins_three_to_seven),
		.out_pins_three_to_seven_oe (out_pins_three_to_seven_oe)
	);
	dui_host host (
		.hclk   (hclk),
		.hready (hready),
		.hrdata (hrdata),
		.hsel   (hsel),
		.haddr  (haddr),
		.htrans (htrans),
		.hwrite (hwrite),
		.hsize  (hsize),
		.hwdata (hwdata)
	);
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		host.xfer(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		host.xfer(1'b1, a, d, q);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask
	task automatic irqn(input logic e);
		// keep clear of the launching edge
		#1;
		chk({31'h0, irq_request_n}, {31'h0, e});
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			stop_test();
		end
	end
	initial begin
		hresetn = 1'b0;
		tx_can_accept = 2'b00;
		rx_char_avail = 2'b00;
		rx_buffer_full = 2'b00;
		break_change = 2'b00;
		rx_data_a = 8'h5a;
		rx_data_b = 8'ha5;
		input_pins = 4'h0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		rd(`DUI_OFF_MASK, 32'h0);
		rd(`DUI_OFF_AUX, 32'h0);
		rd(`DUI_OFF_CT_PRESET, 32'hffff);
		wr(8'h40, 32'hffffffff);
		rd(8'h40, 32'h0);
		chk({27'h0, out_pins_three_to_seven_oe}, 32'h1f);
		$display("test reset done");
		@(posedge hclk) rx_char_avail <= 2'b01;
		tick(3);
		rd(`DUI_OFF_STATUS, 32'h02);
		irqn(1'b1);
		wr(`DUI_OFF_MASK, 32'h02);
		tick(2);
		irqn(1'b0);
		wr(`DUI_OFF_MASK, 32'h00);
		tick(2);
		irqn(1'b1);
		wr(`DUI_OFF_MASK, 32'h02);
		wr(`DUI_OFF_OPCFG, 32'h02);
		tick(3);
		chk({27'h0, out_pins_three_to_seven_oe}, 32'h1f);
		chk({27'h0, out_pins_three_to_seven}, 32'h1d);
		rd(`DUI_OFF_HOLD_A, 32'h5a);
		@(posedge hclk) rx_char_avail <= 2'b00;
		tick(3);
		irqn(1'b1);
		chk({27'h0, out_pins_three_to_seven_oe}, 32'h1d);
		wr(`DUI_OFF_OPCFG, 32'h00);
		$display("test receive done");
		@(posedge hclk) tx_can_accept <= 2'b01;
		wr(`DUI_OFF_MASK, 32'h01);
		tick(2);
		irqn(1'b0);
		wr(`DUI_OFF_HOLD_A, 32'h33);
		tick(2);
		irqn(1'b1);
		chk({24'h0, tx_data}, 32'h33);
		rd(`DUI_OFF_STATUS, 32'h0);
		@(posedge hclk) tx_can_accept <= 2'b00;
		$display("test transmit done");
		@(posedge hclk) break_change <= 2'b10;
		@(posedge hclk) break_change <= 2'b00;
		wr(`DUI_OFF_MASK, 32'h40);
		tick(2);
		irqn(1'b0);
		rd(`DUI_OFF_STATUS, 32'h40);
		rd(`DUI_OFF_STATUS, 32'h40);
		wr(`DUI_OFF_CMD_B, 32'h50);
		tick(2);
		irqn(1'b1);
		rd(`DUI_OFF_STATUS, 32'h0);
		$display("test break done");
		wr(`DUI_OFF_CT_PRESET, 32'h3);
		wr(`DUI_OFF_MASK, 32'h08);
		wr(`DUI_OFF_CT_CTRL, 32'h1);
		tick(20);
		irqn(1'b0);
		rd(`DUI_OFF_STATUS, 32'h08);
		wr(`DUI_OFF_CT_CTRL, 32'h2);
		tick(2);
		irqn(1'b1);
		rd(`DUI_OFF_STATUS, 32'h0);
		$display("test counter done");
		wr(`DUI_OFF_AUX, 32'h1);
		wr(`DUI_OFF_MASK, 32'h80);
		@(posedge hclk) input_pins <= 4'h1;
		tick(30);
		irqn(1'b0);
		rd(`DUI_OFF_STATUS, 32'h80);
		rd(`DUI_OFF_INCHG, 32'h11);
		tick(2);
		irqn(1'b1);
		rd(`DUI_OFF_INCHG, 32'h10);
		$display("test input change done");
		rd(`DUI_OFF_EVT, 32'h1);
		rd(`DUI_OFF_EVT, 32'h0);
		wr(`DUI_OFF_EVT_MASK, 32'h1);
		wr(`DUI_OFF_OPCFG, 32'h4004);
		wr(`DUI_OFF_MASK, 32'h20);
		@(posedge hclk) rx_char_avail <= 2'b10;
		tick(3);
		irqn(1'b1);
		chk({27'h0, out_pins_three_to_seven_oe}, 32'h1b);
		chk({31'h0, irq}, 32'h0);
		@(posedge hclk) rx_buffer_full <= 2'b10;
		tick(3);
		irqn(1'b0);
		chk({31'h0, irq}, 32'h1);
		chk({27'h0, out_pins_three_to_seven_oe}, 32'h1f);
		chk({27'h0, out_pins_three_to_seven}, 32'h1b);
		rd(`DUI_OFF_HOLD_B, 32'ha5);
		@(posedge hclk) rx_buffer_full <= 2'b00;
		tick(3);
		irqn(1'b1);
		rd(`DUI_OFF_EVT, 32'h1);
		tick(2);
		chk({31'h0, irq}, 32'h0);
		$display("test event and buffer full done");
		stop_test();
	end
endmodule
`default_nettype wire
